// ### logic/abm_bus_master.sv
// bus master interface linking a processor core to the system bus
//
// How it works
// - grant tracker on rising edge, two states: granted and ungranted.
// - becomes granted only when grant is high and wait response is low.
// - tracker reset is asynchronous; reset state follows grant during reset.
// - arbiter grants one default master in reset; it comes up granted.
// - tracker state is the internal granted signal feeding the main machine.
// - main machine runs on falling edge with five states.
// - request and granted select idle, hold, granted idle or active.
// - outside active, only granted and request decide transitions.
// - in active, decoded transfer response chooses the next state.
// - responses are captured on rising edge; copies steer active exit.
// - reset forces the main machine into idle.
// - idle: address-only, core clock on, address bus off.
// - granted idle: core transfer type, clock on, enable from granted.
// - hold: address-only, core stalled, address bus off.
// - active: core transfer type, clock from wait, enable from granted.
// - retract: address-only, core stalled, enable from granted.
// - address bus enable shows the core really owns the bus.
// - enable rises on grant without wait, falls when grant drops without wait.
// - core clock enable goes out as an active-low wait to the core.
// - abort to the core on an error response.
`timescale 1ns/10ps
`include "abm_cfg.svh"

module abm_bus_master
	import abm_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_BWAIT,
	input wire logic I_BERROR,
	input wire logic I_BLAST,
	input wire logic I_AGNT,
	input wire logic I_NMREQ_N,
	input wire logic I_SEQ,
	input wire logic I_NOPC_N,
	input wire logic I_NTRANS_N,
	output logic [1:0] O_BTRAN,
	output logic [1:0] O_BPROT,
	output logic O_MABE,
	output logic O_NWAIT_N,
	output logic O_ABORT
);

	// quadrant of the state diagram chosen by request and granted
	function automatic abm_state_type quadrant(input logic req,
			input logic gnt);
		abm_state_type s;
		s = ABM_IDLE;
		case ({req, gnt})
			2'h0: s = ABM_IDLE;
			2'h2: s = ABM_HOLD;
			2'h1: s = ABM_GRANTED_IDLE;
			2'h3: s = ABM_ACTIVE;
			default: s = ABM_IDLE;
		endcase
		return s;
	endfunction

	// transfer type that the core asks for
	function automatic logic [1:0] core_tran(input logic nmreq_n,
			input logic seq);
		logic [1:0] t;
		t = `ABM_TRAN_ADDR_ONLY;
		if (nmreq_n) begin
			t = `ABM_TRAN_ADDR_ONLY;
		end else if (seq) begin
			t = `ABM_TRAN_SEQ;
		end else begin
			t = `ABM_TRAN_NONSEQ;
		end
		return t;
	endfunction

	logic default_q;
	logic first_q;
	logic granted_q;
	logic granted;
	logic bwait_q;
	logic berror_q;
	logic blast_q;
	logic request;
	logic rsp_wait;
	logic rsp_retnext;
	logic rsp_error;
	abm_state_type state_q;
	abm_state_type state_d;

	// ==========================================================
	// grant tracker
	// ==========================================================

	// default-master strap: a flop with async reset may only load a
	// constant, so the grant level seen during reset is caught here
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			default_q <= I_AGNT;
		end
	end

	// marks the first rising edge after reset release
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			first_q <= 1'h0;
		end else begin
			first_q <= 1'h1;
		end
	end

	// during reset and until the first edge the strap stands in
	assign granted = first_q ? granted_q : default_q;

	// two-state tracker; grant only counts while no wait is pending
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			granted_q <= 1'h0;
		end else if (!I_BWAIT) begin
			granted_q <= I_AGNT;
		end else begin
			granted_q <= granted;
		end
	end

	// ==========================================================
	// response capture
	// ==========================================================

	// responses are valid at the rising edge; the falling-edge machine
	// would otherwise see them mid-change
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bwait_q <= 1'h0;
			berror_q <= 1'h0;
			blast_q <= 1'h0;
		end else begin
			bwait_q <= I_BWAIT;
			berror_q <= I_BERROR;
			blast_q <= I_BLAST;
		end
	end

	// decoded response from the captured copies
	assign rsp_retnext = bwait_q & berror_q;
	assign rsp_wait = bwait_q & ~berror_q;
	assign rsp_error = ~bwait_q & berror_q;

	// core keeps its request up until served, so no pending flag is kept
	assign request = ~I_NMREQ_N;

	// ==========================================================
	// main bus interface machine
	// ==========================================================

	// next state; blast only marks the end, it exits like done
	always_comb begin
		state_d = state_q;
		case (state_q)
			ABM_ACTIVE: begin
				if (rsp_retnext) begin
					state_d = ABM_RETRACT;
				end else if (rsp_wait) begin
					state_d = ABM_ACTIVE;
				end else begin
					state_d = quadrant(request, granted);
				end
			end
			ABM_IDLE, ABM_GRANTED_IDLE, ABM_HOLD, ABM_RETRACT: begin
				state_d = quadrant(request, granted);
			end
			default: state_d = ABM_IDLE;
		endcase
	end

	// state register on the falling edge
	always_ff @(negedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= ABM_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// state actions, registered with the state
	// ==========================================================

	// transfer type and protection
	always_ff @(negedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BTRAN <= `ABM_RST_TRAN;
			O_BPROT <= `ABM_RST_PROT;
		end else begin
			O_BPROT <= {I_NTRANS_N, I_NOPC_N};
			case (state_d)
				ABM_GRANTED_IDLE, ABM_ACTIVE: begin
					O_BTRAN <= core_tran(I_NMREQ_N, I_SEQ);
				end
				default: O_BTRAN <= `ABM_TRAN_ADDR_ONLY;
			endcase
		end
	end

	// address bus enable: only a really granted core drives the bus
	always_ff @(negedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_MABE <= `ABM_RST_MABE;
		end else begin
			case (state_d)
				ABM_IDLE, ABM_HOLD: O_MABE <= 1'h0;
				default: O_MABE <= granted;
			endcase
		end
	end

	// core stall: active follows the wait response, hold and retract stall
	always_ff @(negedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_NWAIT_N <= `ABM_RST_NWAIT;
		end else begin
			case (state_d)
				ABM_HOLD, ABM_RETRACT: O_NWAIT_N <= 1'h0;
				ABM_ACTIVE: O_NWAIT_N <= ~bwait_q;
				default: O_NWAIT_N <= 1'h1;
			endcase
		end
	end

	// abort a transfer that ends in error
	always_ff @(negedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ABORT <= `ABM_RST_ABORT;
		end else begin
			O_ABORT <= (state_q == ABM_ACTIVE) & rsp_error;
		end
	end

	// ==========================================================
	// checks
	// ==========================================================

	sequence s_grant_taken;
		!granted && I_AGNT && !I_BWAIT;
	endsequence

	sequence s_grant_stalled;
		!granted && I_AGNT && I_BWAIT;
	endsequence

	sequence s_active_retnext;
		state_q == ABM_ACTIVE && rsp_retnext;
	endsequence

	sequence s_active_wait;
		state_q == ABM_ACTIVE && rsp_wait;
	endsequence

	// a last beat that is neither wait nor error ends like done
	sequence s_active_last;
		state_q == ABM_ACTIVE && blast_q && !bwait_q && !berror_q;
	endsequence

	property p_grant_entry;
		@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		s_grant_taken |=> granted;
	endproperty
	a_grant_entry: assert property (p_grant_entry)
		else $error("grant not taken with wait low");

	property p_grant_stall;
		@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		s_grant_stalled |=> !granted;
	endproperty
	a_grant_stall: assert property (p_grant_stall)
		else $error("grant taken while wait high");

	property p_grant_exit;
		@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		first_q && granted && !I_AGNT && !I_BWAIT |=> !granted;
	endproperty
	a_grant_exit: assert property (p_grant_exit)
		else $error("grant not dropped");

	property p_req_granted;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q != ABM_ACTIVE && request && granted |=> state_q == ABM_ACTIVE;
	endproperty
	a_req_granted: assert property (p_req_granted)
		else $error("request with grant did not reach active");

	property p_req_hold;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q != ABM_ACTIVE && request && !granted
			|=> state_q == ABM_HOLD && !O_NWAIT_N && !O_MABE;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("hold not entered or not stalling");

	property p_retract;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		s_active_retnext |=> state_q == ABM_RETRACT && !O_NWAIT_N
			&& O_BTRAN == `ABM_TRAN_ADDR_ONLY;
	endproperty
	a_retract: assert property (p_retract)
		else $error("retract-next not handled");

	property p_wait;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		s_active_wait |=> state_q == ABM_ACTIVE && !O_NWAIT_N;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait response left active or did not stall");

	property p_idle_out;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q == ABM_IDLE |-> O_BTRAN == `ABM_TRAN_ADDR_ONLY
			&& O_NWAIT_N && !O_MABE;
	endproperty
	a_idle_out: assert property (p_idle_out)
		else $error("idle outputs wrong");

	property p_abort;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q == ABM_ACTIVE && rsp_error |=> O_ABORT;
	endproperty
	a_abort: assert property (p_abort)
		else $error("error response without abort");

	property p_last;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		s_active_last |=> state_q != ABM_RETRACT && !O_ABORT;
	endproperty
	a_last: assert property (p_last)
		else $error("last response mishandled");

	property p_hold_out;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q == ABM_HOLD |-> O_BTRAN == `ABM_TRAN_ADDR_ONLY
			&& !O_NWAIT_N && !O_MABE;
	endproperty
	a_hold_out: assert property (p_hold_out)
		else $error("hold outputs wrong");

	property p_gidle_out;
		@(negedge I_CLK_SYS) disable iff (!I_RST_N)
		state_q == ABM_GRANTED_IDLE |-> O_NWAIT_N;
	endproperty
	a_gidle_out: assert property (p_gidle_out)
		else $error("core stalled while granted idle");

endmodule

// ### logic/abm_cfg.svh
// constants for the bus master interface: transfer codes and reset values
`ifndef ABM_CFG_SVH
`define ABM_CFG_SVH

// transfer type codes driven on the bus transfer-type lines
`define ABM_TRAN_ADDR_ONLY 2'h0
`define ABM_TRAN_NONSEQ 2'h2
`define ABM_TRAN_SEQ 2'h3

// reset values of the outputs
`define ABM_RST_TRAN 2'h0
`define ABM_RST_PROT 2'h0
`define ABM_RST_MABE 1'h0
`define ABM_RST_NWAIT 1'h1
`define ABM_RST_ABORT 1'h0

`endif

// ### logic/abm_pkg.sv
// types shared by the bus master interface
package abm_pkg;

	// main bus interface states, one-hot
	typedef enum logic [4:0] {
		ABM_IDLE = 5'h01,
		ABM_GRANTED_IDLE = 5'h02,
		ABM_HOLD = 5'h04,
		ABM_ACTIVE = 5'h08,
		ABM_RETRACT = 5'h10
	} abm_state_type;

endpackage

// ### test/abm_far_model.sv
// far-side model: arbiter grant and multiplexed slave response lines
`timescale 1ns/10ps

module abm_far_model (
	input wire logic i_give,
	input wire logic [2:0] i_resp,
	output logic o_agnt,
	output logic o_bwait,
	output logic o_berror,
	output logic o_blast
);
	// ==========================
	// arbiter
	// only one default master is granted in reset, so the bench decides
	// whether that master is this one
	assign o_agnt = i_give;

	// ==========================
	// decoder and slaves
	// codes: 0 done, 1 wait, 2 error, 3 retract-next, 4 last; the lines
	// change with the bench's falling-edge drive, never near the rise
	always_comb begin
		o_bwait = (i_resp == 3'h1) || (i_resp == 3'h3);
		o_berror = (i_resp == 3'h2) || (i_resp == 3'h3);
		o_blast = (i_resp == 3'h4);
	end
endmodule

// ### test/tb_top.sv
// self-checking bench for the bus master interface
`timescale 1ns/10ps
`include "abm_cfg.svh"

module tb_top;
	localparam logic [2:0] DONE = 3'h0;
	localparam logic [2:0] WT = 3'h1;
	localparam logic [2:0] ERR = 3'h2;
	localparam logic [2:0] RETR = 3'h3;
	localparam logic [2:0] LAST = 3'h4;
	logic clk, rst_n, give, req_n, seq, opc_n, trans_n;
	logic [2:0] resp;
	logic agnt, bwait, berror, blast, mabe, nwait_n, abort;
	logic [1:0] btran, bprot;
	int fail_count, n_compared;

	// ==========================
	// parts
	abm_far_model i_far (.i_give(give), .i_resp(resp), .o_agnt(agnt),
		.o_bwait(bwait), .o_berror(berror), .o_blast(blast));
	abm_bus_master i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
		.I_BWAIT(bwait), .I_BERROR(berror), .I_BLAST(blast),
		.I_AGNT(agnt), .I_NMREQ_N(req_n), .I_SEQ(seq), .I_NOPC_N(opc_n),
		.I_NTRANS_N(trans_n), .O_BTRAN(btran), .O_BPROT(bprot),
		.O_MABE(mabe), .O_NWAIT_N(nwait_n), .O_ABORT(abort));

	// ==========================
	// helpers
	task automatic chk(input string what, input logic [1:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// all outputs but bprot at once
	task automatic outs(input logic [1:0] tr, input logic mb, nw, ab);
		chk("btran", tr, btran);
		chk("mabe", {1'b0, mb}, {1'b0, mabe});
		chk("nwait_n", {1'b0, nw}, {1'b0, nwait_n});
		chk("abort", {1'b0, ab}, {1'b0, abort});
	endtask
	// drive at one fall; the next fall acts on it, checked 1 ns later
	task automatic go(input logic rq, sq, input logic [2:0] rs,
		input logic gv);
		@(negedge clk);
		req_n <= ~rq;
		seq <= sq;
		resp <= rs;
		give <= gv;
		@(negedge clk);
		#1;
	endtask
	task automatic do_reset(input logic gv);
		@(negedge clk);
		rst_n <= 1'b0;
		give <= gv;
		req_n <= 1'b1;
		resp <= DONE;
		repeat (10) @(posedge clk);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h0, 1'h1, 1'h0);
		@(negedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================
	// scenarios
	task automatic t_default();
		do_reset(1'h1);
		go(1'h0, 1'h0, DONE, 1'h1);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h1, 1'h1, 1'h0);
		do_reset(1'h0);
		go(1'h0, 1'h0, DONE, 1'h0);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h0, 1'h1, 1'h0);
	endtask
	// grant offered while another transfer waits must not be taken
	task automatic t_hold();
		for (int i = 0; i < 3; i++) begin
			go(1'h1, 1'h0, WT, 1'h1);
			outs(`ABM_TRAN_ADDR_ONLY, 1'h0, 1'h0, 1'h0);
		end
		go(1'h1, 1'h0, DONE, 1'h1);
		outs(`ABM_TRAN_NONSEQ, 1'h1, 1'h1, 1'h0);
		chk("bprot", {trans_n, opc_n}, bprot);
	endtask
	// request stays up through wait and error until the transfer ends
	task automatic t_wait_abort();
		go(1'h1, 1'h1, WT, 1'h1);
		outs(`ABM_TRAN_SEQ, 1'h1, 1'h0, 1'h0);
		go(1'h1, 1'h1, ERR, 1'h1);
		outs(`ABM_TRAN_SEQ, 1'h1, 1'h1, 1'h1);
		go(1'h1, 1'h1, LAST, 1'h1);
		outs(`ABM_TRAN_SEQ, 1'h1, 1'h1, 1'h0);
	endtask
	task automatic t_retract();
		go(1'h1, 1'h0, RETR, 1'h1);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h1, 1'h0, 1'h0);
		go(1'h1, 1'h0, DONE, 1'h1);
		outs(`ABM_TRAN_NONSEQ, 1'h1, 1'h1, 1'h0);
	endtask
	// grant removal only counts once the bus stops waiting
	task automatic t_release();
		go(1'h0, 1'h0, DONE, 1'h1);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h1, 1'h1, 1'h0);
		go(1'h0, 1'h0, WT, 1'h0);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h1, 1'h1, 1'h0);
		go(1'h0, 1'h0, DONE, 1'h0);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h0, 1'h1, 1'h0);
		go(1'h1, 1'h0, DONE, 1'h0);
		outs(`ABM_TRAN_ADDR_ONLY, 1'h0, 1'h0, 1'h0);
	endtask

	// ==========================
	// clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		fail_count = 0;
		n_compared = 0;
		rst_n = 1'b0;
		give = 1'b0;
		req_n = 1'b1;
		seq = 1'b0;
		opc_n = 1'b0;
		trans_n = 1'b1;
		resp = DONE;
		t_default();
		t_hold();
		t_wait_abort();
		t_retract();
		t_release();
		tally_and_finish();
	end
endmodule
